// >>> pkg/field_ctrl_pkg.sv
package field_ctrl_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_BACK_EMF = 8'h00;
   localparam logic [7:0] OFF_FIELD_DEMAND = 8'h04;
   localparam logic [7:0] OFF_FIELD_FEEDBACK = 8'h08;
   localparam logic [7:0] OFF_FIRING_ANGLE = 8'h0c;
   localparam logic [7:0] OFF_IR_DROP_OUT = 8'h10;
   localparam logic [7:0] OFF_IR_DROP_FACTOR = 8'h14;
   localparam logic [7:0] OFF_EMF_SET_POINT = 8'h18;
   localparam logic [7:0] OFF_MAX_PRIMARY = 8'h1c;
   localparam logic [7:0] OFF_MAX_ECONOMY = 8'h20;
   localparam logic [7:0] OFF_MIN_FIELD = 8'h24;
   localparam logic [7:0] OFF_FB_SCALE = 8'h28;
   localparam logic [7:0] OFF_ECO_TIMEOUT = 8'h2c;
   localparam logic [7:0] OFF_CONTROL = 8'h30;
   localparam logic [7:0] OFF_FRONT_ENDSTOP = 8'h34;
   localparam logic [7:0] OFF_SPEED_GAIN = 8'h38;

   // control register bit positions
   localparam int BIT_FIELD_EN = 0;
   localparam int BIT_ECO_SEL = 1;
   localparam int BIT_ECO_EN = 2;
   localparam int BIT_TC_SEL = 3;
   localparam int BIT_GAIN_DBL = 4;
   localparam int BIT_SPD_ADJ = 5;
   localparam int BIT_DIRECT = 6;
   localparam int BIT_IR_SRC = 7;

   // reset values
   localparam logic [7:0] RST_IR_DROP_FACTOR = 8'h00;
   localparam logic [9:0] RST_EMF_SET_POINT = 10'h190;
   localparam logic [9:0] RST_MAX_PRIMARY = 10'h3e8;
   localparam logic [9:0] RST_MAX_ECONOMY = 10'h1f4;
   localparam logic [9:0] RST_MIN_FIELD = 10'h1f4;
   localparam logic [6:0] RST_FB_SCALE = 7'h6e;
   localparam logic [7:0] RST_ECO_TIMEOUT = 8'h1e;
   localparam logic [9:0] RST_FRONT_ENDSTOP = 10'h3e8;

   // ranges
   localparam logic [9:0] FULL_SCALE = 10'h3e8;
   localparam logic [9:0] FIRING_MIN = 10'h105;
   localparam logic [6:0] FB_SCALE_MAX = 7'h70;
   localparam int FB_SCALE_SHIFT = 7;
   localparam int IR_DIV_SHIFT = 11;

   // timing at 25 MHz
   localparam int CLK_HZ = 25000000;
   localparam int SAMPLE_US = 40;
   localparam int SAMPLE_CYCLES = SAMPLE_US * (CLK_HZ / 1000000);
   localparam int SECOND_S = 1;
   localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;

   // loop shifts
   localparam int VL_SHIFT_FAST = 4;
   localparam int VL_SHIFT_SLOW = 6;
   localparam int CL_SHIFT_FAST = 2;
   localparam int CL_SHIFT_SLOW = 4;

   typedef struct packed {
      logic [7:0] ir_drop_factor;
      logic [9:0] emf_set_point;
      logic [9:0] max_field_primary;
      logic [9:0] max_field_economy;
      logic [9:0] min_field_current;
      logic [6:0] feedback_scale;
      logic [7:0] economy_timeout_seconds;
      logic [9:0] firing_front_endstop;
      logic field_control_enable;
      logic economy_ceiling_user;
      logic economy_timer_enable;
      logic time_constant_select;
      logic integral_gain_double;
      logic speed_gain_adjust_enable;
      logic direct_firing_enable;
      logic ir_drop_source_select;
   } params_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

endpackage

// >>> src/economy_timer.sv
`timescale 1ns/100ps
module economy_timer #(
   parameter int SECOND_CYCLES = field_ctrl_pkg::SECOND_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control
   input wire logic drive_enabled,
   input wire logic [7:0] timeout_seconds,
   // result
   output logic timed_out
);
   typedef struct packed {
      logic [24:0] presc;
      logic [8:0] secs;
      logic out;
   } state_s;

   state_s s_q;
   state_s s_d;

   always_comb begin
      s_d = s_q;
      if (drive_enabled) begin
         s_d.presc = '0;
         s_d.secs = '0;
      end else if (s_q.presc == 25'(SECOND_CYCLES - 1)) begin
         s_d.presc = '0; // [R22]
         if (s_q.secs != 9'h1ff) begin
            s_d.secs = s_q.secs + 9'h001;
         end
      end else begin
         s_d.presc = s_q.presc + 25'h0000001;
      end
      s_d.out = !drive_enabled && (s_q.secs >= {1'b0, timeout_seconds}); // [R10]
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_q <= '0; // [R23]
      end else begin
         s_q <= s_d;
      end
   end

   assign timed_out = s_q.out;

   chk_eco_clear_on_enable: assert property (@(posedge core_clk) disable iff (!resetn)
      drive_enabled |=> (s_q.secs == 9'h000) && !timed_out) else $error("economy count not cleared"); // [R10]
endmodule // economy_timer

// >>> src/field_loops.sv
`timescale 1ns/100ps
module field_loops (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // sample strobe and settings
   input wire logic tick,
   input wire field_ctrl_pkg::params_s prm,
   input wire logic economy_active,
   // measurements
   input wire logic [9:0] back_emf,
   input wire logic [9:0] field_feedback,
   // results
   output logic [9:0] field_demand,
   output logic [9:0] firing_angle
);
   typedef struct packed {
      logic signed [17:0] v_int;
      logic signed [17:0] c_int;
      logic [9:0] demand;
      logic [9:0] firing;
   } state_s;

   state_s s_q;
   state_s s_d;

   function automatic logic signed [17:0] clamp18(input logic signed [17:0] v, input logic [9:0] hi);
      logic signed [17:0] r;
      r = v;
      if (v < 18'sd0) begin
         r = 18'sd0;
      end else if (v > $signed({8'h00, hi})) begin
         r = $signed({8'h00, hi});
      end
      return r;
   endfunction

   logic [9:0] ceiling;
   logic [9:0] lo_lim;
   logic [9:0] endstop;
   logic signed [17:0] v_err;
   logic signed [17:0] c_err;
   logic signed [17:0] c_out;
   int vsh;
   int csh;

   always_comb begin
      s_d = s_q;
      ceiling = economy_active ? prm.max_field_economy : prm.max_field_primary; // [R6] [R7] [R11]
      lo_lim = (prm.min_field_current > ceiling) ? ceiling : prm.min_field_current;
      endstop = (prm.firing_front_endstop < field_ctrl_pkg::FIRING_MIN) ?
         field_ctrl_pkg::FIRING_MIN : prm.firing_front_endstop;
      vsh = prm.time_constant_select ? field_ctrl_pkg::VL_SHIFT_SLOW : field_ctrl_pkg::VL_SHIFT_FAST; // [R14]
      csh = prm.time_constant_select ? field_ctrl_pkg::CL_SHIFT_SLOW : field_ctrl_pkg::CL_SHIFT_FAST; // [R14]
      // voltage loop: positive error raises demand up to the ceiling
      v_err = $signed({8'h00, prm.emf_set_point}) - $signed({8'h00, back_emf}); // [R5] [R20]
      if (prm.integral_gain_double) begin
         v_err = v_err <<< 1; // [R15]
      end
      c_err = $signed({8'h00, s_q.demand}) - $signed({8'h00, field_feedback}); // [R21]
      c_out = clamp18(s_q.c_int + (c_err <<< csh), endstop);
      if (!prm.field_control_enable) begin
         s_d = '0; // [R13]
         s_d.firing = field_ctrl_pkg::FIRING_MIN;
      end else if (tick) begin
         s_d.v_int = clamp18(s_q.v_int + (v_err <<< (10 - vsh)), ceiling); // [R20]
         s_d.demand = s_q.v_int[9:0];
         if (s_q.v_int[9:0] > ceiling) begin
            s_d.demand = ceiling; // [R2]
         end else if (s_q.v_int[9:0] < lo_lim) begin
            s_d.demand = lo_lim; // [R8]
         end
         s_d.c_int = clamp18(s_q.c_int + (c_err >>> csh), endstop);
         if (prm.direct_firing_enable) begin
            s_d.firing = (prm.max_field_primary > endstop) ? endstop : prm.max_field_primary; // [R17]
         end else begin
            s_d.firing = c_out[9:0]; // [R21]
         end
         if (s_d.firing < field_ctrl_pkg::FIRING_MIN) begin
            s_d.firing = field_ctrl_pkg::FIRING_MIN; // [R3]
         end
         if (s_d.firing > endstop) begin
            s_d.firing = endstop; // [R19]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.firing <= field_ctrl_pkg::FIRING_MIN;
      end else begin
         s_q <= s_d;
      end
   end

   assign field_demand = s_q.demand;
   assign firing_angle = s_q.firing;

   chk_firing_range: assert property (@(posedge core_clk) disable iff (!resetn)
      firing_angle >= field_ctrl_pkg::FIRING_MIN && firing_angle <= field_ctrl_pkg::FULL_SCALE)
      else $error("firing angle out of range"); // [R3]
   chk_firing_endstop: assert property (@(posedge core_clk) disable iff (!resetn)
      tick && prm.field_control_enable && prm.firing_front_endstop >= field_ctrl_pkg::FIRING_MIN
      |=> firing_angle <= $past(prm.firing_front_endstop)) else $error("firing beyond endstop"); // [R19]
   chk_demand_ceiling: assert property (@(posedge core_clk) disable iff (!resetn)
      tick && prm.field_control_enable |=> field_demand <= $past(ceiling))
      else $error("demand above ceiling"); // [R2]
   chk_demand_floor: assert property (@(posedge core_clk) disable iff (!resetn)
      tick && prm.field_control_enable |=> field_demand >= $past(lo_lim))
      else $error("demand below minimum"); // [R8]
   chk_direct_firing: assert property (@(posedge core_clk) disable iff (!resetn)
      tick && prm.field_control_enable && prm.direct_firing_enable && prm.max_field_primary <= endstop
      && prm.max_field_primary >= field_ctrl_pkg::FIRING_MIN
      |=> firing_angle == $past(prm.max_field_primary)) else $error("direct firing mismatch"); // [R17]
   chk_disabled_idle: assert property (@(posedge core_clk) disable iff (!resetn)
      !prm.field_control_enable |=> field_demand == 10'h000) else $error("demand while disabled"); // [R13]
endmodule // field_loops

// >>> src/dc_motor_field_control.sv
`timescale 1ns/100ps
// Summary of operation
// [R1] back emf is armature voltage minus IR correction, clamped 0 to 1000
// [R2] field demand is voltage loop output clamped between ceiling and minimum
// [R3] firing angle output spans 261 to 1000, 1000 fully forward
// [R4] IR correction is source times 8-bit factor divided by 2048, signed
// [R5] emf set point, default 400, where the voltage loop starts weakening
// [R6] maximum field 1, default 1000, caps demand and acts as reference
// [R7] maximum field 2, default 500, is the economy ceiling when selected
// [R8] minimum field current, default 500, is the floor of demand
// [R9] field feedback is measured current times scale 0 to 112, default 110
// [R10] economy selects field 2 after drive disabled for programmed seconds
// [R11] selector bit 1 engages maximum field 2; reset value 0
// [R12] economy enabled: timer drives selector; otherwise user writes it
// [R13] field control enable bit, reset 0, gates the field loops; IR, back emf and economy timer keep running
// [R14] time constant bit picks slow or fast loop tuning
// [R15] gain bit doubles voltage loop integral gain
// [R16] speed gain factor is maximum field 1 over field demand when enabled
// [R17] direct firing mode drives firing angle from maximum field 1
// [R18] IR source bit picks speed error integral or speed reference 4
// [R19] firing angle never exceeds the front endstop or 261, whichever is higher
// [R20] voltage loop gives full demand below set point, regulates above
// [R21] current loop error is demand minus feedback, output is firing angle
// [R22] loops update on a sample tick; one-second prescaler feeds timer
// [R23] reset loads all defaults and clears the economy counter
module dc_motor_field_control #(
   parameter int SAMPLE_CYCLES = field_ctrl_pkg::SAMPLE_CYCLES,
   parameter int SECOND_CYCLES = field_ctrl_pkg::SECOND_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive measurements
   input wire logic drive_enable,
   input wire logic [9:0] armature_voltage,
   input wire logic [9:0] field_current_meas,
   input wire logic signed [10:0] speed_error_integral,
   input wire logic signed [10:0] speed_reference_4,
   // field bridge and speed loop outputs
   output logic [9:0] firing_angle,
   output logic [9:0] field_demand,
   output logic [15:0] speed_gain_factor
);
   typedef struct packed {
      field_ctrl_pkg::params_s prm;
      field_ctrl_pkg::apb_rsp_s rsp;
      logic [1:0] drv_sync;
      logic [15:0] tick_cnt;
      logic tick;
      logic [9:0] back_emf;
      logic [9:0] feedback;
      logic signed [10:0] ir_out;
      logic [15:0] gain;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic eco_timed_out;
   logic [9:0] loop_demand;
   logic [9:0] loop_firing;
   logic eco_active;

   function automatic logic [9:0] sat10(input logic signed [19:0] v, input logic [9:0] hi);
      logic [9:0] r;
      r = v[9:0];
      if (v < 20'sd0) begin
         r = 10'h000;
      end else if (v > $signed({10'h000, hi})) begin
         r = hi;
      end
      return r;
   endfunction

   economy_timer #(
      .SECOND_CYCLES(SECOND_CYCLES)
   ) u_eco (
      .core_clk(core_clk),
      .resetn(resetn),
      .drive_enabled(s_q.drv_sync[1]),
      .timeout_seconds(s_q.prm.economy_timeout_seconds),
      .timed_out(eco_timed_out)
   );

   // economy ceiling selection
   assign eco_active = s_q.prm.economy_timer_enable ? eco_timed_out : s_q.prm.economy_ceiling_user; // [R12]

   field_loops u_loops (
      .core_clk(core_clk),
      .resetn(resetn),
      .tick(s_q.tick),
      .prm(s_q.prm),
      .economy_active(eco_active),
      .back_emf(s_q.back_emf),
      .field_feedback(s_q.feedback),
      .field_demand(loop_demand),
      .firing_angle(loop_firing)
   );

   logic signed [10:0] ir_src;
   logic signed [19:0] ir_prod;
   logic signed [19:0] emf_calc;
   logic [16:0] fb_prod;
   logic [25:0] gain_num;
   logic [9:0] rd_scale;
   logic access;

   always_comb begin
      s_d = s_q;
      s_d.drv_sync = {s_q.drv_sync[0], drive_enable};
      // sample tick
      s_d.tick = 1'b0;
      if (s_q.tick_cnt == 16'(SAMPLE_CYCLES - 1)) begin
         s_d.tick_cnt = 16'h0000; // [R22]
         s_d.tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
      end
      // IR drop correction
      ir_src = s_q.prm.ir_drop_source_select ? speed_reference_4 : speed_error_integral; // [R18]
      ir_prod = 20'(ir_src * $signed({1'b0, s_q.prm.ir_drop_factor}));
      s_d.ir_out = 11'(ir_prod >>> field_ctrl_pkg::IR_DIV_SHIFT); // [R4]
      // back emf
      emf_calc = $signed({10'h000, armature_voltage}) - 20'(s_q.ir_out);
      s_d.back_emf = sat10(emf_calc, field_ctrl_pkg::FULL_SCALE); // [R1]
      // field feedback scaling
      fb_prod = 17'(field_current_meas * s_q.prm.feedback_scale);
      s_d.feedback = sat10($signed({3'b000, fb_prod >> field_ctrl_pkg::FB_SCALE_SHIFT}),
         field_ctrl_pkg::FULL_SCALE); // [R9]
      // speed gain factor in 8.8 fixed point
      gain_num = {s_q.prm.max_field_primary, 16'h0000} >> 8;
      if (!s_q.prm.speed_gain_adjust_enable || loop_demand == 10'h000) begin
         s_d.gain = 16'h0100;
      end else begin
         s_d.gain = 16'(gain_num / 26'(loop_demand)); // [R16]
      end
      // apb
      access = psel && penable && !s_q.rsp.pready;
      s_d.rsp.pready = access;
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata = '0;
      rd_scale = {3'b000, s_q.prm.feedback_scale};
      if (access) begin
         unique case (paddr)
            field_ctrl_pkg::OFF_BACK_EMF: s_d.rsp.prdata = {22'h0, s_q.back_emf};
            field_ctrl_pkg::OFF_FIELD_DEMAND: s_d.rsp.prdata = {22'h0, loop_demand};
            field_ctrl_pkg::OFF_FIELD_FEEDBACK: s_d.rsp.prdata = {22'h0, s_q.feedback};
            field_ctrl_pkg::OFF_FIRING_ANGLE: s_d.rsp.prdata = {22'h0, loop_firing};
            field_ctrl_pkg::OFF_IR_DROP_OUT: s_d.rsp.prdata = {21'h0, s_q.ir_out};
            field_ctrl_pkg::OFF_SPEED_GAIN: s_d.rsp.prdata = {16'h0, s_q.gain};
            field_ctrl_pkg::OFF_IR_DROP_FACTOR: begin
               s_d.rsp.prdata = {24'h0, s_q.prm.ir_drop_factor};
               if (pwrite) s_d.prm.ir_drop_factor = pwdata[7:0];
            end
            field_ctrl_pkg::OFF_EMF_SET_POINT: begin
               s_d.rsp.prdata = {22'h0, s_q.prm.emf_set_point};
               if (pwrite) s_d.prm.emf_set_point = sat10({10'h000, pwdata[9:0]}, field_ctrl_pkg::FULL_SCALE);
            end
            field_ctrl_pkg::OFF_MAX_PRIMARY: begin
               s_d.rsp.prdata = {22'h0, s_q.prm.max_field_primary};
               if (pwrite) s_d.prm.max_field_primary = sat10({10'h000, pwdata[9:0]}, field_ctrl_pkg::FULL_SCALE);
            end
            field_ctrl_pkg::OFF_MAX_ECONOMY: begin
               s_d.rsp.prdata = {22'h0, s_q.prm.max_field_economy};
               if (pwrite) s_d.prm.max_field_economy = sat10({10'h000, pwdata[9:0]}, field_ctrl_pkg::FULL_SCALE);
            end
            field_ctrl_pkg::OFF_MIN_FIELD: begin
               s_d.rsp.prdata = {22'h0, s_q.prm.min_field_current};
               if (pwrite) s_d.prm.min_field_current = sat10({10'h000, pwdata[9:0]}, field_ctrl_pkg::FULL_SCALE);
            end
            field_ctrl_pkg::OFF_FB_SCALE: begin
               s_d.rsp.prdata = {22'h0, rd_scale};
               if (pwrite) begin
                  s_d.prm.feedback_scale = (pwdata[6:0] > field_ctrl_pkg::FB_SCALE_MAX) ?
                     field_ctrl_pkg::FB_SCALE_MAX : pwdata[6:0]; // [R9]
               end
            end
            field_ctrl_pkg::OFF_ECO_TIMEOUT: begin
               s_d.rsp.prdata = {24'h0, s_q.prm.economy_timeout_seconds};
               if (pwrite) s_d.prm.economy_timeout_seconds = pwdata[7:0];
            end
            field_ctrl_pkg::OFF_CONTROL: begin
               s_d.rsp.prdata = {24'h0, s_q.prm.ir_drop_source_select, s_q.prm.direct_firing_enable,
                  s_q.prm.speed_gain_adjust_enable, s_q.prm.integral_gain_double,
                  s_q.prm.time_constant_select, s_q.prm.economy_timer_enable, eco_active,
                  s_q.prm.field_control_enable};
               if (pwrite) begin
                  s_d.prm.field_control_enable = pwdata[field_ctrl_pkg::BIT_FIELD_EN]; // [R13]
                  if (!s_q.prm.economy_timer_enable) begin
                     s_d.prm.economy_ceiling_user = pwdata[field_ctrl_pkg::BIT_ECO_SEL]; // [R11] [R12]
                  end
                  s_d.prm.economy_timer_enable = pwdata[field_ctrl_pkg::BIT_ECO_EN];
                  s_d.prm.time_constant_select = pwdata[field_ctrl_pkg::BIT_TC_SEL];
                  s_d.prm.integral_gain_double = pwdata[field_ctrl_pkg::BIT_GAIN_DBL];
                  s_d.prm.speed_gain_adjust_enable = pwdata[field_ctrl_pkg::BIT_SPD_ADJ];
                  s_d.prm.direct_firing_enable = pwdata[field_ctrl_pkg::BIT_DIRECT];
                  s_d.prm.ir_drop_source_select = pwdata[field_ctrl_pkg::BIT_IR_SRC];
               end
            end
            field_ctrl_pkg::OFF_FRONT_ENDSTOP: begin
               s_d.rsp.prdata = {22'h0, s_q.prm.firing_front_endstop};
               if (pwrite) s_d.prm.firing_front_endstop = sat10({10'h000, pwdata[9:0]}, field_ctrl_pkg::FULL_SCALE);
            end
            default: s_d.rsp.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s_q <= '0; // [R23]
         s_q.prm.ir_drop_factor <= field_ctrl_pkg::RST_IR_DROP_FACTOR;
         s_q.prm.emf_set_point <= field_ctrl_pkg::RST_EMF_SET_POINT;
         s_q.prm.max_field_primary <= field_ctrl_pkg::RST_MAX_PRIMARY;
         s_q.prm.max_field_economy <= field_ctrl_pkg::RST_MAX_ECONOMY;
         s_q.prm.min_field_current <= field_ctrl_pkg::RST_MIN_FIELD;
         s_q.prm.feedback_scale <= field_ctrl_pkg::RST_FB_SCALE;
         s_q.prm.economy_timeout_seconds <= field_ctrl_pkg::RST_ECO_TIMEOUT;
         s_q.prm.firing_front_endstop <= field_ctrl_pkg::RST_FRONT_ENDSTOP;
         s_q.gain <= 16'h0100;
         firing_angle <= field_ctrl_pkg::FIRING_MIN;
         field_demand <= 10'h000;
      end else begin
         s_q <= s_d;
         firing_angle <= loop_firing;
         field_demand <= loop_demand;
      end
   end

   assign prdata = s_q.rsp.prdata;
   assign pready = s_q.rsp.pready;
   assign pslverr = s_q.rsp.pslverr;
   assign speed_gain_factor = s_q.gain;

   chk_emf_bound: assert property (@(posedge core_clk) disable iff (!resetn)
      s_q.back_emf <= field_ctrl_pkg::FULL_SCALE) else $error("back emf above full scale"); // [R1]
   chk_ir_zero_factor: assert property (@(posedge core_clk) disable iff (!resetn)
      s_q.prm.ir_drop_factor == 8'h00 ##1 s_q.prm.ir_drop_factor == 8'h00 |-> s_q.ir_out == 11'sd0)
      else $error("IR output nonzero with zero factor"); // [R4]
   chk_user_sel_locked: assert property (@(posedge core_clk) disable iff (!resetn)
      s_q.prm.economy_timer_enable |=> $stable(s_q.prm.economy_ceiling_user))
      else $error("selector written while timer owns it"); // [R12]
   chk_gain_unity: assert property (@(posedge core_clk) disable iff (!resetn)
      !s_q.prm.speed_gain_adjust_enable |=> speed_gain_factor == 16'h0100)
      else $error("gain adjusted while disabled"); // [R16]
   chk_apb_one_wait: assert property (@(posedge core_clk) disable iff (!resetn)
      psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule // dc_motor_field_control

// >>> dv/field_bridge_model.sv
`timescale 1ns/100ps
module field_bridge_model (
   // bridge command and winding current
   input wire logic core_clk,
   input wire logic [9:0] firing_angle,
   output logic [9:0] field_current_meas
);
   // winding current trails the firing angle by one cycle
   always @(posedge core_clk) begin
      field_current_meas <= firing_angle - 10'h0c8;
   end
endmodule // field_bridge_model

// >>> dv/dc_motor_field_control_bench.sv
`timescale 1ns/100ps
module dc_motor_field_control_bench;
   logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, drive_enable, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [9:0] armature_voltage, field_current_meas, firing_angle, field_demand;
   logic signed [10:0] speed_error_integral, speed_reference_4;
   logic [15:0] speed_gain_factor;
   int n_mismatch, tests_run, v;
   dc_motor_field_control #(.SAMPLE_CYCLES(4), .SECOND_CYCLES(10)) u_dc_motor_field_control (.core_clk, .resetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_enable, .armature_voltage,
      .field_current_meas, .speed_error_integral, .speed_reference_4, .firing_angle, .field_demand,
      .speed_gain_factor);
   field_bridge_model u_field_bridge_model (.core_clk, .firing_angle, .field_current_meas);
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wt(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(n, x, r);
   endtask
   // poll a result port until it reaches the model value, bounded
   task automatic settle(input string n, input bit f, input logic [9:0] x);
      int i;
      for (i = 0; i < 3000 && (f ? firing_angle : field_demand) !== x; i++) @(posedge core_clk);
      chk(n, {22'h0, x}, {22'h0, f ? firing_angle : field_demand});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #2000000;
      n_mismatch++;
      results();
   end
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, armature_voltage} = '0;
      {speed_error_integral, speed_reference_4} = '0;
      drive_enable = 1'b1;
      v = $urandom(32'h57f67428);
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      rd("ir_factor", 8'h14, field_ctrl_pkg::RST_IR_DROP_FACTOR);
      rd("set_point", 8'h18, field_ctrl_pkg::RST_EMF_SET_POINT);
      rd("max1", 8'h1c, field_ctrl_pkg::RST_MAX_PRIMARY);
      rd("max2", 8'h20, field_ctrl_pkg::RST_MAX_ECONOMY);
      rd("min", 8'h24, field_ctrl_pkg::RST_MIN_FIELD);
      rd("scale", 8'h28, field_ctrl_pkg::RST_FB_SCALE);
      rd("timeout", 8'h2c, field_ctrl_pkg::RST_ECO_TIMEOUT);
      rd("endstop", 8'h34, field_ctrl_pkg::RST_FRONT_ENDSTOP);
      rd("control", 8'h30, 32'h0);
      $display("test defaults done");
      apb(1'b0, 8'h3c, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      wt(8'h00, 32'h155);
      rd("back_emf_ro", 8'h00, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom % 1024;
         wt(8'(8'h18 + i * 4), v);
         rd("saturate", 8'(8'h18 + i * 4), v > 1000 ? 1000 : v);
      end
      wt(8'h28, 32'd127);
      rd("scale_clamp", 8'h28, 32'd112);
      wt(8'h28, 32'd110);
      rd("feedback", 8'h08, (261 - 200) * 110 / 128);
      chk("off_firing", 32'd261, {22'h0, firing_angle});
      chk("off_demand", 32'd0, {22'h0, field_demand});
      chk("unity_gain", 32'h100, {16'h0, speed_gain_factor});
      $display("test registers done");
      wt(8'h14, 32'd8);
      speed_error_integral <= -11'sd512;
      speed_reference_4 <= 11'sd512;
      armature_voltage <= 10'd300;
      rd("ir_integral", 8'h10, 32'h7fe);
      rd("emf_integral", 8'h00, 32'd302);
      wt(8'h30, 32'h80);
      rd("ir_ref4", 8'h10, 32'd2);
      rd("emf_ref4", 8'h00, 32'd298);
      $display("test ir drop done");
      wt(8'h1c, 32'd700);
      wt(8'h30, 32'h41);
      settle("direct", 1'b1, 10'd700);
      wt(8'h34, 32'd600);
      settle("endstop", 1'b1, 10'd600);
      wt(8'h34, 32'd100);
      settle("firing_floor", 1'b1, 10'd261);
      $display("test direct firing done");
      wt(8'h34, 32'd1000);
      wt(8'h18, 32'd1000);
      armature_voltage <= 10'd0;
      wt(8'h1c, 32'd800);
      wt(8'h30, 32'h39);
      settle("full_demand", 1'b0, 10'd800);
      wt(8'h20, 32'd500);
      wt(8'h30, 32'h23);
      rd("user_select", 8'h30, 32'h23);
      settle("economy_cap", 1'b0, 10'd500);
      wt(8'h24, 32'd400);
      wt(8'h18, 32'd0);
      armature_voltage <= 10'd1000;
      wt(8'h30, 32'h21);
      settle("min_demand", 1'b0, 10'd400);
      repeat (8) @(posedge core_clk);
      chk("speed_gain", 32'h200, {16'h0, speed_gain_factor});
      $display("test loops done");
      wt(8'h2c, 32'd3);
      wt(8'h30, 32'h07);
      rd("hw_owned", 8'h30, 32'h05);
      drive_enable <= 1'b0;
      repeat (12) @(posedge core_clk);
      rd("not_yet", 8'h30, 32'h05);
      repeat (40) @(posedge core_clk);
      rd("timed_out", 8'h30, 32'h07);
      drive_enable <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd("re_enable", 8'h30, 32'h05);
      wt(8'h30, 32'h01);
      rd("sel_kept", 8'h30, 32'h03);
      $display("test economy done");
      results();
   end
endmodule // dc_motor_field_control_bench
